// >>> hw/card_cmd_pkg.sv
/*
 Constants for the card block command decoder: command indices,
 reset values, frame layout and buffer shape.
 Assumes a 100 MHz core clock and a sampled host bus clock.
*/
// Behaviour
// - block-length command sets the 32-bit byte length for later transfers
// - block length is 512 bytes from reset until first block-length command
// - writes need a 512-byte block length; other lengths raise a write error
// - single read sends one block of block length from the byte address
// - multiple read keeps sending consecutive blocks until stop command
// - single write takes one block and stores it from the argument address
// - multiple write keeps storing consecutive blocks until stop command
// - each written block gets a data token, then busy while programming
// - program command updates only programmable card data bits
// - don't-care argument bits are sent but their values are ignored
// - set-protect sets the group bit holding the address, then busy
// - clear-protect clears the group bit holding the address, then busy
// - send-protect returns protection bits from the given group onward
// - erase-start records the first block of the erase range
// - erase-end records the last block of the erase range
// - erase command erases the recorded range, ignores argument, then busy
// - prefix with matching address bits 31:16 marks next command as app
// - general data command moves one block, direction from argument bit 0
// - driver stage set command is unsupported and refused
// - data addresses are 32-bit byte addresses, up to 4 gigabytes
// - stop command ends any multiple read or write in progress
// - direction bit one sends to host, zero receives from host
package card_cmd_pkg;
   localparam logic [5:0]   CMD_DRV     = 6'h04;
   localparam logic [5:0]   CMD_STOP    = 6'h0c;
   localparam logic [5:0]   CMD_BLKLEN  = 6'h10;
   localparam logic [5:0]   CMD_RD1     = 6'h11;
   localparam logic [5:0]   CMD_RDN     = 6'h12;
   localparam logic [5:0]   CMD_WR1     = 6'h18;
   localparam logic [5:0]   CMD_WRN     = 6'h19;
   localparam logic [5:0]   CMD_PCSD    = 6'h1b;
   localparam logic [5:0]   CMD_SETWP   = 6'h1c;
   localparam logic [5:0]   CMD_CLRWP   = 6'h1d;
   localparam logic [5:0]   CMD_SNDWP   = 6'h1e;
   localparam logic [5:0]   CMD_ERS     = 6'h20;
   localparam logic [5:0]   CMD_ERE     = 6'h21;
   localparam logic [5:0]   CMD_ERASE   = 6'h26;
   localparam logic [5:0]   CMD_APP     = 6'h37;
   localparam logic [5:0]   CMD_GEN     = 6'h38;
   localparam logic [31:0]  BLKLEN_RST  = 32'h0000_0200;
   localparam logic [31:0]  WR_BLKLEN   = 32'h0000_0200;
   localparam logic [31:0]  WP_LEN      = 32'h0000_0004;
   localparam logic [31:0]  SPEC_LEN    = 32'h0000_0010;
   localparam logic [5:0]   FRAME_LAST  = 6'h2f;
   localparam logic [4:0]   CRC_LAST    = 5'h10;
   localparam int           WP_GROUPS   = 64;
   localparam logic [127:0] SPEC_RST    = 128'h0;
   localparam logic [127:0] SPEC_MASK   = 128'h0000_fe00;
   localparam int           FIFO_WIDTH  = 8;
   localparam int           FIFO_DEPTH  = 16;
endpackage

// >>> hw/card_block_cmd_decoder.sv
/*
 Card command decoder for block, protect, erase, app and general data
 commands, with a byte FIFO in the write data path.
 Assumes host bus clock and lines are asynchronous, memory and read
 stream sit on ref_clk.
*/
`timescale 1ns/10ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic             clkEn,
   // fill side
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  inReady,
   // drain side
   output logic                  outValid,
   output logic      [WIDTH-1:0] outData,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr;
   logic [AW-1:0]    rdPtr;
   logic [AW:0]      count;
   wire              doPush = inValid && inReady;
   wire              doPop  = outValid && outReady;

   // full and empty from the occupancy count
   assign inReady  = count != (AW+1)'(DEPTH);
   assign outValid = count != '0;
   assign outData  = mem[rdPtr];

   // storage array
   always_ff @(posedge ref_clk)
      if (clkEn && doPush)
         mem[wrPtr] <= inData;

   // pointers and count
   always_ff @(posedge ref_clk or negedge reset_n)
      if (!reset_n)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end
      else if (clkEn)
      begin
         if (doPush)
            wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
         if (doPop)
            rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
         count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
      end
endmodule

module card_block_cmd_decoder (
   // clock, reset, enable
   input  wire logic         ref_clk,
   input  wire logic         reset_n,
   input  wire logic         clkEn,
   // host bus pins
   input  wire logic         busClk,
   input  wire logic         cmdLine,
   input  wire logic         datIn,
   // configuration
   input  wire logic [15:0]  relativeCardAddress,
   input  wire logic [4:0]   protectGroupSize,
   // command report
   output logic              cmdValid,
   output logic      [5:0]   cmdIndex,
   output logic      [31:0]  cmdArg,
   output logic              cmdApp,
   output logic              respIllegal,
   output logic              writeError,
   output logic              busy,
   output logic              dataToken,
   output logic              dataInReady,
   output logic              genCmd,
   // memory port
   output logic              memWrite,
   output logic              memRead,
   output logic      [31:0]  memAddr,
   output logic      [7:0]   memWdata,
   input  wire logic         memReady,
   input  wire logic         memRvalid,
   input  wire logic [7:0]   memRdata,
   // read stream to host
   output logic              readValid,
   output logic      [7:0]   readData,
   output logic              readLast,
   input  wire logic         readReady,
   // erase port
   output logic              eraseReq,
   output logic      [31:0]  eraseFirst,
   output logic      [31:0]  eraseLast,
   input  wire logic         eraseDone,
   // card specific data
   output logic      [127:0] cardSpecificData
);
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_RX   = 4'b0010,
      ST_RD   = 4'b0100,
      ST_BUSY = 4'b1000
   } state_t;

   function automatic logic isReserved(input logic [5:0] i);
      isReserved = (i == card_cmd_pkg::CMD_DRV) ||
                   (i >= 6'h13 && i <= 6'h17) || i == 6'h1a ||
                   i == 6'h1f || (i >= 6'h22 && i <= 6'h25) ||
                   (i >= 6'h27 && i <= 6'h29) || i >= 6'h39;
   endfunction

   // protection group that holds a byte address
   function automatic logic [5:0] grpOf(input logic [31:0] a,
                                        input logic [4:0]  s);
      grpOf = 6'(a >> s);
   endfunction

   state_t        state;
   logic [2:0]    clkSync;
   logic [1:0]    cmdSync;
   logic [1:0]    datSync;
   logic [47:0]   cmdShift;
   logic [5:0]    cmdBits;
   logic          cmdActive;
   logic          frameDone;
   logic          appPending;
   logic [31:0]   blkLen;
   logic [31:0]   xferLen;
   logic [31:0]   rdCnt;
   logic          rdPend;
   logic          multi;
   logic          srcWp;
   logic          specMode;
   logic          stopSeen;
   logic          eraseWait;
   logic [63:0]   wpBits;
   logic [5:0]    wpBase;
   logic          rxStarted;
   logic [2:0]    bitCnt;
   logic [7:0]    rxByte;
   logic [31:0]   rxCnt;
   logic [4:0]    crcCnt;
   logic          pushValid;
   logic [7:0]    pushData;
   logic [3:0]    specIdx;
   logic          fifoInReady;
   logic          fifoOutValid;
   logic [7:0]    fifoOutData;
   logic [31:0]   wpWord;

   // link edge and frame field decode
   wire        clkRise  = clkSync[1] && !clkSync[2];
   wire [5:0]  idx      = cmdShift[45:40];
   wire [31:0] arg      = cmdShift[39:8];
   wire        isIdle   = state == ST_IDLE;
   wire        ownCmd   = idx == card_cmd_pkg::CMD_BLKLEN ||
                          idx == card_cmd_pkg::CMD_RD1 ||
                          idx == card_cmd_pkg::CMD_RDN ||
                          idx == card_cmd_pkg::CMD_WR1 ||
                          idx == card_cmd_pkg::CMD_WRN ||
                          idx == card_cmd_pkg::CMD_PCSD ||
                          (idx >= card_cmd_pkg::CMD_SETWP &&
                           idx <= card_cmd_pkg::CMD_SNDWP) ||
                          idx == card_cmd_pkg::CMD_ERS ||
                          idx == card_cmd_pkg::CMD_ERE ||
                          idx == card_cmd_pkg::CMD_ERASE ||
                          idx == card_cmd_pkg::CMD_GEN;
   wire        illegal  = frameDone && !appPending &&
                          (isReserved(idx) || (!isIdle && ownCmd));
   wire        act      = frameDone && !appPending && !illegal;
   wire        isGen    = idx == card_cmd_pkg::CMD_GEN;
   wire        startRd  = act && isIdle &&
                          (idx == card_cmd_pkg::CMD_RD1 ||
                           idx == card_cmd_pkg::CMD_RDN ||
                           idx == card_cmd_pkg::CMD_SNDWP ||
                           (isGen && arg[0]));
   wire        wantWr   = act && isIdle &&
                          (idx == card_cmd_pkg::CMD_WR1 ||
                           idx == card_cmd_pkg::CMD_WRN ||
                           idx == card_cmd_pkg::CMD_PCSD ||
                           (isGen && !arg[0]));
   wire        pcsd     = idx == card_cmd_pkg::CMD_PCSD;
   wire        wrBad    = !pcsd && blkLen != card_cmd_pkg::WR_BLKLEN;
   wire        startWr  = wantWr && !wrBad;
   wire        stopCmd  = act && idx == card_cmd_pkg::CMD_STOP;
   wire        wpCmd    = act && isIdle &&
                          (idx == card_cmd_pkg::CMD_SETWP ||
                           idx == card_cmd_pkg::CMD_CLRWP);
   wire        eraseCmd = act && isIdle &&
                          idx == card_cmd_pkg::CMD_ERASE;
   wire        rxBit    = clkRise && state == ST_RX && rxStarted;
   wire        rxData   = rxBit && rxCnt < xferLen;
   wire        blkEnd   = rxBit && rxCnt >= xferLen &&
                          crcCnt == card_cmd_pkg::CRC_LAST;
   wire        popReady = specMode || !memWrite || memReady;
   wire        drained  = !fifoOutValid && !memWrite && !pushValid &&
                          !eraseWait;
   wire        rdMore   = rdCnt < xferLen;
   wire        rdDone   = readValid && readReady && readLast;
   wire [7:0]  wpByte   = wpWord[8*rdCnt[1:0] +: 8];

   // protection status word starting at the requested group
   always_comb
   begin
      wpWord = '0;
      for (int k = 0; k < 32; k++)
         wpWord[k] = wpBits[6'(wpBase + 6'(k))];
   end

   // two-flop synchronisers for the host bus pins
   always_ff @(posedge ref_clk or negedge reset_n)
      if (!reset_n)
      begin
         clkSync <= 3'h0;
         cmdSync <= 2'h3;
         datSync <= 2'h3;
      end
      else if (clkEn)
      begin
         clkSync <= {clkSync[1:0], busClk};
         cmdSync <= {cmdSync[0], cmdLine};
         datSync <= {datSync[0], datIn};
      end

   // command frame shifter, start bit opens a 48-bit frame
   always_ff @(posedge ref_clk or negedge reset_n)
      if (!reset_n)
      begin
         cmdShift  <= '0;
         cmdBits   <= 6'h0;
         cmdActive <= 1'b0;
         frameDone <= 1'b0;
      end
      else if (clkEn)
      begin
         frameDone <= 1'b0;
         if (clkRise && (cmdActive || !cmdSync[1]))
         begin
            cmdShift  <= {cmdShift[46:0], cmdSync[1]};
            cmdBits   <= cmdActive ? cmdBits + 6'h1 : 6'h1;
            cmdActive <= !(cmdActive &&
                           cmdBits == card_cmd_pkg::FRAME_LAST);
            frameDone <= cmdActive &&
                         cmdBits == card_cmd_pkg::FRAME_LAST;
         end
      end

   // command report, app prefix and configuration registers
   always_ff @(posedge ref_clk or negedge reset_n)
      if (!reset_n)
      begin
         cmdValid    <= 1'b0;
         cmdIndex    <= 6'h0;
         cmdArg      <= 32'h0;
         cmdApp      <= 1'b0;
         respIllegal <= 1'b0;
         appPending  <= 1'b0;
         blkLen      <= card_cmd_pkg::BLKLEN_RST;
         eraseFirst  <= 32'h0;
         eraseLast   <= 32'h0;
         wpBits      <= 64'h0;
      end
      else if (clkEn)
      begin
         cmdValid    <= frameDone;
         respIllegal <= illegal;
         if (frameDone)
         begin
            cmdIndex <= idx;
            cmdArg   <= arg;
            cmdApp   <= appPending;
            appPending <= !appPending && !illegal &&
                          idx == card_cmd_pkg::CMD_APP &&
                          arg[31:16] == relativeCardAddress;
         end
         if (act && isIdle && idx == card_cmd_pkg::CMD_BLKLEN)
            blkLen <= arg;
         if (act && isIdle && idx == card_cmd_pkg::CMD_ERS)
            eraseFirst <= arg;
         if (act && isIdle && idx == card_cmd_pkg::CMD_ERE)
            eraseLast <= arg;
         if (wpCmd)
            wpBits[grpOf(arg, protectGroupSize)] <=
               idx == card_cmd_pkg::CMD_SETWP;
      end

   // transfer state machine
   always_ff @(posedge ref_clk or negedge reset_n)
      if (!reset_n)
      begin
         state     <= ST_IDLE;
         multi     <= 1'b0;
         srcWp     <= 1'b0;
         specMode  <= 1'b0;
         genCmd    <= 1'b0;
         stopSeen  <= 1'b0;
         eraseWait <= 1'b0;
         eraseReq  <= 1'b0;
         xferLen   <= 32'h0;
         wpBase    <= 6'h0;
         busy      <= 1'b0;
      end
      else if (clkEn)
      begin
         eraseReq <= 1'b0;
         busy     <= state == ST_BUSY;
         if (eraseDone)
            eraseWait <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               stopSeen <= 1'b0;
               multi    <= idx == card_cmd_pkg::CMD_RDN ||
                           idx == card_cmd_pkg::CMD_WRN;
               srcWp    <= idx == card_cmd_pkg::CMD_SNDWP;
               specMode <= pcsd;
               genCmd   <= isGen;
               wpBase   <= grpOf(arg, protectGroupSize);
               xferLen  <= pcsd ? card_cmd_pkg::SPEC_LEN :
                           idx == card_cmd_pkg::CMD_SNDWP ?
                           card_cmd_pkg::WP_LEN : blkLen;
               if (startRd)
                  state <= ST_RD;
               else if (startWr)
                  state <= ST_RX;
               else if (wpCmd || eraseCmd)
                  state <= ST_BUSY;
               if (eraseCmd)
               begin
                  eraseReq  <= 1'b1;
                  eraseWait <= 1'b1;
               end
            end
            ST_RX:
            begin
               if (stopCmd)
                  stopSeen <= 1'b1;
               if (blkEnd || (stopCmd && !rxStarted))
                  state <= ST_BUSY;
            end
            ST_RD:
               if (stopCmd || (rdDone && !multi))
                  state <= ST_IDLE;
            ST_BUSY:
               if (drained)
                  state <= (multi && !stopSeen && !stopCmd) ? ST_RX : ST_IDLE;
            default:
               state <= ST_IDLE;
         endcase
         if (stopCmd && state == ST_BUSY)
            stopSeen <= 1'b1;
      end

   // serial data receiver, start bit then bytes then crc bits
   always_ff @(posedge ref_clk or negedge reset_n)
      if (!reset_n)
      begin
         rxStarted  <= 1'b0;
         bitCnt     <= 3'h0;
         rxByte     <= 8'h0;
         rxCnt      <= 32'h0;
         crcCnt     <= 5'h0;
         pushValid  <= 1'b0;
         pushData   <= 8'h0;
         dataToken  <= 1'b0;
         writeError <= 1'b0;
      end
      else if (clkEn)
      begin
         pushValid  <= 1'b0;
         dataToken  <= blkEnd;
         writeError <= (wantWr && wrBad) ||
                       (pushValid && !fifoInReady);
         if (clkRise && state == ST_RX && !rxStarted && !datSync[1])
            rxStarted <= 1'b1;
         if (rxData)
         begin
            rxByte <= {rxByte[6:0], datSync[1]};
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == 3'h7)
            begin
               pushValid <= 1'b1;
               pushData  <= {rxByte[6:0], datSync[1]};
               rxCnt     <= rxCnt + 32'h1;
            end
         end
         else if (rxBit)
            crcCnt <= crcCnt + 5'h1;
         if (blkEnd || state == ST_IDLE)
         begin
            rxStarted <= 1'b0;
            rxCnt     <= 32'h0;
            crcCnt    <= 5'h0;
            bitCnt    <= 3'h0;
         end
      end

   byte_fifo #(
      .WIDTH (card_cmd_pkg::FIFO_WIDTH),
      .DEPTH (card_cmd_pkg::FIFO_DEPTH)
   ) u_fifo (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .clkEn    (clkEn),
      .inValid  (pushValid),
      .inData   (pushData),
      .inReady  (fifoInReady),
      .outValid (fifoOutValid),
      .outData  (fifoOutData),
      .outReady (popReady)
   );

   // fifo drain into memory or card specific data
   always_ff @(posedge ref_clk or negedge reset_n)
      if (!reset_n)
      begin
         memWrite         <= 1'b0;
         memWdata         <= 8'h0;
         memAddr          <= 32'h0;
         specIdx          <= 4'h0;
         dataInReady      <= 1'b0;
         cardSpecificData <= card_cmd_pkg::SPEC_RST;
      end
      else if (clkEn)
      begin
         dataInReady <= fifoInReady;
         // address steps on each accepted write
         if (memWrite && memReady)
         begin
            memWrite <= 1'b0;
            memAddr  <= memAddr + 32'h1;
         end
         if (startWr || startRd)
            memAddr <= arg;
         if ((startWr || startRd) && isGen)
            memAddr <= 32'h0;
         if (startWr)
            specIdx <= 4'h0;
         if (fifoOutValid && popReady && specMode)
         begin
            cardSpecificData[8*(15-specIdx) +: 8] <=
               (cardSpecificData[8*(15-specIdx) +: 8] &
                ~card_cmd_pkg::SPEC_MASK[8*(15-specIdx) +: 8]) |
               (fifoOutData &
                card_cmd_pkg::SPEC_MASK[8*(15-specIdx) +: 8]);
            specIdx <= specIdx + 4'h1;
         end
         else if (fifoOutValid && popReady)
         begin
            memWrite <= 1'b1;
            memWdata <= fifoOutData;
         end
         else if (memRead)
            memAddr <= memAddr + 32'h1;
      end

   // read stream from memory or protection bits
   always_ff @(posedge ref_clk or negedge reset_n)
      if (!reset_n)
      begin
         memRead   <= 1'b0;
         rdPend    <= 1'b0;
         rdCnt     <= 32'h0;
         readValid <= 1'b0;
         readData  <= 8'h0;
         readLast  <= 1'b0;
      end
      else if (clkEn)
      begin
         memRead <= 1'b0;
         if (state != ST_RD || stopCmd)
         begin
            rdCnt     <= 32'h0;
            rdPend    <= 1'b0;
            readValid <= readValid && !stopCmd && !readReady;
         end
         else if (readValid && readReady)
         begin
            readValid <= 1'b0;
            if (readLast && multi)
               rdCnt <= 32'h0;
         end
         else if (!readValid && !rdPend && rdMore && srcWp)
         begin
            readValid <= 1'b1;
            readData  <= wpByte;
            readLast  <= rdCnt + 32'h1 == xferLen;
            rdCnt     <= rdCnt + 32'h1;
         end
         else if (!readValid && !rdPend && rdMore)
         begin
            memRead <= 1'b1;
            rdPend  <= 1'b1;
         end
         else if (rdPend && memRvalid)
         begin
            rdPend    <= 1'b0;
            readValid <= 1'b1;
            readData  <= memRdata;
            readLast  <= rdCnt + 32'h1 == xferLen;
            rdCnt     <= rdCnt + 32'h1;
         end
      end
endmodule

// >>> dv/card_cmd_props.sv
/* port checker for the card command decoder
   bound to every decoder instance by the bind below */
`timescale 1ns/10ps
module card_cmd_props (
   // watched ports
   input wire logic        ref_clk, reset_n, cmdValid, respIllegal, cmdApp,
   input wire logic        writeError, busy, dataToken, readValid,
   input wire logic        readReady, memWrite, memReady, eraseReq,
   input wire logic [5:0]  cmdIndex,
   input wire logic [7:0]  readData, memWdata,
   input wire logic [31:0] memAddr
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   ill_with_frame_a: assert property (respIllegal |-> cmdValid)
      else $error("refusal outside a frame report");
   drive_cmd_a: assert property (cmdValid && !cmdApp && cmdIndex == 6'h04
      |-> respIllegal)
      else $error("drive stage command accepted");
   rsvd_refused_a: assert property (cmdValid && !cmdApp && cmdIndex inside
      {[6'h13:6'h17]} |-> respIllegal)
      else $error("reserved index accepted");
   len_error_a: assert property (cmdValid && writeError |->
      cmdIndex inside {6'h18, 6'h19, 6'h38})
      else $error("length error on a non-write frame");
   token_busy_a: assert property (dataToken |=> busy)
      else $error("no busy after data token");
   erase_cmd_a: assert property (eraseReq |-> cmdIndex == 6'h26)
      else $error("erase without erase command");
   read_hold_a: assert property (readValid && !readReady |=>
      readValid && $stable(readData) || cmdValid && cmdIndex == 6'h0c)
      else $error("read byte dropped while stalled");
   mem_hold_a: assert property (memWrite && !memReady |=> memWrite
      && $stable(memAddr) && $stable(memWdata))
      else $error("memory write changed while stalled");
endmodule
bind card_block_cmd_decoder card_cmd_props u_card_cmd_props (.ref_clk,
   .reset_n, .cmdValid, .respIllegal, .writeError, .busy, .dataToken,
   .readValid, .readReady, .memWrite, .memReady, .eraseReq, .cmdIndex,
   .readData, .memWdata, .memAddr, .cmdApp);

// >>> dv/card_host_model.sv
/* host side of the card bus: command frames and write blocks
   assumes the card samples on the rising link clock edge */
`timescale 1ns/10ps
module card_host_model (
   // host bus pins
   output logic busClk,
   output logic cmdLine,
   output logic datIn
);
   // link clock rests low, lines pulled high
   initial {busClk, cmdLine, datIn} = 3'b011;
   // one bit time of 80 ns
   task automatic tick(input logic c, input logic d);
      cmdLine = c;
      datIn = d;
      #40 busClk = 1'b1;
      #40 busClk = 1'b0;
   endtask
   task automatic send(input logic [5:0] i, input logic [31:0] a);
      logic [47:0] f;
      f = {2'b01, i, a, 7'h00, 1'b1};
      for (int k = 47; k >= 0; k--) tick(f[k], 1'b1);
   endtask
   // start bit, byte k holds k mod 256, msb first, then 17 ignored bits
   task automatic block(input int n);
      logic [7:0] v;
      tick(1'b1, 1'b0);
      for (int k = 0; k < n * 8; k++)
      begin
         v = 8'(k >> 3);
         tick(1'b1, v[7 - k % 8]);
      end
      repeat (17) tick(1'b1, 1'b1);
   endtask
endmodule

// >>> dv/card_block_cmd_decoder_test.sv
/* self-checking bench for the card command decoder
   memory and erase engine answer from here, host from the model */
`timescale 1ns/10ps
module card_block_cmd_decoder_test;
   logic ref_clk, reset_n, clkEn, busClk, cmdLine, datIn, toggle, rq, er;
   logic cmdValid, cmdApp, respIllegal, writeError, busy, dataToken;
   logic memWrite, memRead, memRvalid, readValid, readLast, eraseReq;
   logic eraseDone, gotIll, gotErr, gotApp, readReady, memReady;
   logic [31:0] memAddr, eraseFirst, eraseLast, base;
   logic [7:0]  memWdata, memRdata, readData, ra;
   int          bad_count, checks, rdN, wrN, tokN, n;
   card_block_cmd_decoder u_card_block_cmd_decoder (.ref_clk, .reset_n,
      .clkEn, .busClk, .cmdLine, .datIn, .relativeCardAddress(16'h1234),
      .protectGroupSize(5'h09), .cmdValid, .cmdIndex(), .cmdArg(),
      .cmdApp, .respIllegal, .writeError, .busy, .dataToken,
      .dataInReady(), .genCmd(), .memWrite, .memRead, .memAddr,
      .memWdata, .memReady, .memRvalid, .memRdata, .readValid, .readData,
      .readLast, .readReady, .eraseReq, .eraseFirst, .eraseLast,
      .eraseDone, .cardSpecificData());
   card_host_model u_card_host_model (.busClk, .cmdLine, .datIn);
   // stalls on every other cycle for both streams
   assign readReady = toggle;
   assign memReady = toggle;
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // memory echoes the low address byte, erase ends next cycle
   always @(posedge ref_clk)
   begin
      {rq, ra, er} = {memRead, memAddr[7:0], eraseReq};
      #1 toggle <= ~toggle;
      {memRvalid, memRdata, eraseDone} <= {rq, ra, er};
   end
   // frame outcomes and stream beats
   always @(posedge ref_clk)
   begin
      if (cmdValid)
         {gotIll, gotErr, gotApp} <= {respIllegal, writeError, cmdApp};
      if (readValid && readReady)
         chk(32'(readData), 32'(rdN[7:0]), "read byte");
      if (readValid && readReady)
         rdN <= rdN + 1;
      if (memWrite && memReady)
         chk(memAddr, base + 32'(wrN), "write address");
      if (memWrite && memReady)
         chk(32'(memWdata), 32'(wrN[7:0]), "write byte");
      if (memWrite && memReady)
         wrN <= wrN + 1;
      if (dataToken)
         tokN <= tokN + 1;
   end
   task automatic chk(input logic [31:0] got, exp, input string m);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value %0t %s", $time, m);
      end
   endtask
   task automatic flag(input logic g, e, input string m);
      chk(32'(g), 32'(e), m);
   endtask
   task automatic cmd(input logic [5:0] i, input logic [31:0] a);
      u_card_host_model.send(i, a);
      repeat (10) @(posedge ref_clk);
      #1;
   endtask
   task automatic wait_for(input int lim);
      for (n = 0; n < lim && !(rdN >= 512 || (tokN > 0 && !busy)); n++)
         @(posedge ref_clk);
      repeat (20) @(posedge ref_clk);
   endtask
   task automatic t_read;
      {base, rdN} = {32'h400, 32'd0};
      cmd(card_cmd_pkg::CMD_RD1, base);
      wait_for(5000);
      chk(32'(rdN), 32'd512, "single block length");
      cmd(card_cmd_pkg::CMD_RDN, base);
      repeat (2000) @(posedge ref_clk);
      cmd(card_cmd_pkg::CMD_STOP, 32'h0);
      n = rdN;
      repeat (300) @(posedge ref_clk);
      chk(32'(rdN), 32'(n), "read after stop");
      flag(rdN > 1024, 1'b1, "blocks continue");
      $display("read test done");
   endtask
   task automatic t_refuse;
      logic [5:0] r[4] = '{6'h04, 6'h13, 6'h17, 6'h22};
      foreach (r[k])
      begin
         cmd(r[k], 32'hffff_ffff);
         flag(gotIll, 1'b1, "reserved refused");
      end
      cmd(card_cmd_pkg::CMD_APP, 32'h1234_beef);
      cmd(card_cmd_pkg::CMD_BLKLEN, 32'd512);
      flag(gotApp, 1'b1, "app prefix");
      cmd(card_cmd_pkg::CMD_ERS, 32'h0000_1000);
      cmd(card_cmd_pkg::CMD_ERE, 32'h0000_3e00);
      cmd(card_cmd_pkg::CMD_ERASE, 32'hffff_ffff);
      chk(eraseFirst, 32'h0000_1000, "erase first");
      chk(eraseLast, 32'h0000_3e00, "erase last");
      flag(busy, 1'b0, "erase busy ended");
      $display("refuse test done");
   endtask
   task automatic t_write;
      {base, wrN, tokN} = {32'h800, 32'd0, 32'd0};
      cmd(card_cmd_pkg::CMD_BLKLEN, 32'd256);
      cmd(card_cmd_pkg::CMD_WR1, base);
      flag(gotErr, 1'b1, "short length write");
      cmd(card_cmd_pkg::CMD_BLKLEN, 32'd512);
      cmd(card_cmd_pkg::CMD_WR1, base);
      flag(gotErr, 1'b0, "full length write");
      u_card_host_model.block(512);
      wait_for(2000);
      chk(32'(wrN), 32'd512, "bytes stored");
      chk(32'(tokN), 32'd1, "data tokens");
      $display("write test done");
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // main sequence after six reset cycles
   initial
   begin
      {reset_n, clkEn, toggle, memRvalid, memRdata, eraseDone} = 13'h0000;
      {bad_count, checks, rdN, wrN, tokN} = 160'h0;
      clkEn = 1'b1;
      repeat (6) @(posedge ref_clk);
      #1 reset_n = 1'b1;
      repeat (5) @(posedge ref_clk);
      t_read();
      t_refuse();
      t_write();
      end_sim();
   end
   // watchdog well past the expected run
   initial
   begin
      #700000;
      bad_count++;
      end_sim();
   end
endmodule
